// ### rtl/eci_params.svh
`ifndef ECI_PARAMS_SVH
`define ECI_PARAMS_SVH
// Notes on behaviour
// - The controller is enabled while the module-on bit 15 is one and disabled while it is zero.
// - With stop-in-idle bit 13 set, transfers pause while the device is idle, otherwise they continue.
// - Writing one to transmit request bit 9 starts sending the described packets, and hardware clears it when all are sent.
// - Writing zero to transmit request lets the packet in progress finish and starts no further packets;
// the code still sends the next packet if the clear comes between back-to-back packets.
// - With receive enable bit 8 set, received packets are stored, and with it clear none are stored.
// - The transmit bus-error flag bit 14 sets on a transmit DMA bus error and clears only on reset or a write of one to the clear alias.
// - The receive bus-error flag bit 13 sets on a receive DMA bus error and clears on reset or a write of one to the clear alias.
// - The empty-watermark flag bit 9 sets while the buffer count is at or below the empty level, clears on a hardware increment, and ignores writes.
// - The full-watermark flag bit 8 sets while the buffer count is at or above the full level, clears on a decrement, and ignores writes.
// - Writing one to buffer-count-decrement bit 0 decrements the receive descriptor buffer count by one.
// - Unimplemented flag register bits, including 31 down to 15, read as zero and ignore writes.
`define ECI_OFF_CTRL 8'h00
`define ECI_OFF_CTRL_CLR 8'h04
`define ECI_OFF_CTRL_SET 8'h08
`define ECI_OFF_CTRL_INV 8'h0c
`define ECI_OFF_IRQ 8'h10
`define ECI_OFF_IRQ_CLR 8'h14
`define ECI_OFF_IRQ_SET 8'h18
`define ECI_OFF_IRQ_INV 8'h1c
`define ECI_OFF_WMARK 8'h20
`define ECI_OFF_STAT 8'h24
`define ECI_CTRL_MASK 32'hffff_a391
`define ECI_IRQ_MASK 32'h0000_6300
`define ECI_BIT_ON 15
`define ECI_BIT_STOP_IN_IDLE 13
`define ECI_BIT_TXREQ 9
`define ECI_BIT_RECEIVE_ENABLE 8
`define ECI_BIT_BUFDEC 0
`define ECI_BIT_TRANSMIT_BUS_ERROR_FLAG 14
`define ECI_BIT_RECEIVE_BUS_ERROR_FLAG 13
`define ECI_BIT_EWM 9
`define ECI_BIT_FWM 8
`define ECI_RESET_WMARK 32'h0000_0000
`define ECI_FIFO_DEPTH 16
`define ECI_FIFO_AW 4
`endif

// ### rtl/eci_pkg.sv
package eci_pkg;
  typedef enum logic [2:0] {
    ECI_TX_IDLE = 3'b001,
    ECI_TX_SEND = 3'b010,
    ECI_TX_LAST = 3'b100
  } eci_tx_e;
  typedef logic [1:0] eci_resp_t;
endpackage : eci_pkg

// ### rtl/eci_fifo.sv
`timescale 1ns/10ps
module eci_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic do_wr;
  logic do_rd;

  // Full and empty from pointer distance
  assign level = wr_q - rd_q;
  assign in_ready = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem[rd_q[AW-1:0]];

  // Storage
  always_ff @(posedge aclk) begin
    if (do_wr) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (do_wr) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_rd) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : eci_fifo

// ### rtl/eci_ctrl.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "eci_params.svh"
module eci_ctrl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // System state
  input wire logic idle_mode,
  // Transmit packet source
  input wire logic tx_desc_valid,
  input wire logic [31:0] tx_desc_data,
  input wire logic tx_desc_last,
  output logic tx_desc_ready,
  output logic tx_out_valid,
  output logic [31:0] tx_out_data,
  input wire logic tx_out_ready,
  // Receive side
  input wire logic rx_pkt_valid,
  output logic rx_pkt_store,
  input wire logic rx_desc_inc,
  // DMA bus errors
  input wire logic tx_bus_error,
  input wire logic rx_bus_error,
  // Controls seen by the datapath
  output logic module_on,
  output logic receive_enable,
  output logic [15:0] pause_timer_value,
  output logic [7:0] descriptor_buffer_count,
  output logic irq
);
  logic [31:0] ctrl_q;
  logic [31:0] irq_q;
  logic [31:0] wmark_q;
  logic [7:0] descriptor_buffer_count_q;
  logic run;
  logic aw_q;
  logic w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] rdata_d;
  logic bufdec;
  logic buf_inc;
  logic tx_done_pulse;
  logic txf_valid;
  logic txf_ready;
  logic last_q;
  eci_pkg::eci_tx_e tx_q;

  // Module-on and idle pause gate all transfers except the drain of the transmit buffer
  assign run = ctrl_q[`ECI_BIT_ON] && !(ctrl_q[`ECI_BIT_STOP_IN_IDLE] && idle_mode);
  assign module_on = ctrl_q[`ECI_BIT_ON];
  assign receive_enable = ctrl_q[`ECI_BIT_RECEIVE_ENABLE];
  assign pause_timer_value = ctrl_q[31:16];
  assign descriptor_buffer_count = descriptor_buffer_count_q;
  assign rx_pkt_store = rx_pkt_valid && run && ctrl_q[`ECI_BIT_RECEIVE_ENABLE];

  // Write channel capture, address and data in either order
  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_bresp = 2'h0;

  // Byte-enable mask and aliasing of the written word
  always_comb begin
    wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wval = wdata_q & wmask;
  end
  assign bufdec = wr_go && wval[`ECI_BIT_BUFDEC] && run && (descriptor_buffer_count_q != 8'h00) &&
                  (awaddr_q == `ECI_OFF_CTRL || awaddr_q == `ECI_OFF_CTRL_SET);
  assign buf_inc = rx_desc_inc && run && (descriptor_buffer_count_q != 8'hff);

  // Control register, transmit request cleared by hardware when done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= 32'h0000_0000;
    end else begin
      logic [31:0] nxt;
      nxt = ctrl_q;
      unique case (wr_go ? awaddr_q : 8'hff)
        `ECI_OFF_CTRL: nxt = (ctrl_q & ~wmask) | wval;
        `ECI_OFF_CTRL_CLR: nxt = ctrl_q & ~wval;
        `ECI_OFF_CTRL_SET: nxt = ctrl_q | wval;
        `ECI_OFF_CTRL_INV: nxt = ctrl_q ^ wval;
        default: nxt = ctrl_q;
      endcase
      if (tx_done_pulse) begin
        nxt[`ECI_BIT_TXREQ] = 1'b0;
      end
      nxt[`ECI_BIT_BUFDEC] = 1'b0; // Self-clearing strobe
      ctrl_q <= nxt & `ECI_CTRL_MASK;
    end
  end

  // Watermark levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wmark_q <= `ECI_RESET_WMARK;
    end else if (wr_go && awaddr_q == `ECI_OFF_WMARK) begin
      wmark_q <= ((wmark_q & ~wmask) | wval) & 32'h00ff_00ff;
    end
  end

  // Receive descriptor buffer count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      descriptor_buffer_count_q <= 8'h00;
    end else if (buf_inc && !bufdec) begin
      descriptor_buffer_count_q <= descriptor_buffer_count_q + 8'h01;
    end else if (bufdec && !buf_inc) begin
      descriptor_buffer_count_q <= descriptor_buffer_count_q - 8'h01;
    end
  end

  // Interrupt flags, hardware set wins over software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 32'h0000_0000;
    end else begin
      logic [31:0] nxt;
      nxt = irq_q;
      unique case (wr_go ? awaddr_q : 8'hff)
        `ECI_OFF_IRQ: nxt = (irq_q & ~wmask) | wval;
        `ECI_OFF_IRQ_CLR: nxt = irq_q & ~wval;
        `ECI_OFF_IRQ_SET: nxt = irq_q | wval;
        `ECI_OFF_IRQ_INV: nxt = irq_q ^ wval;
        default: nxt = irq_q;
      endcase
      // Bus-error flags fall only through the clear alias
      if (!(wr_go && awaddr_q == `ECI_OFF_IRQ_CLR)) begin
        nxt[`ECI_BIT_TRANSMIT_BUS_ERROR_FLAG] = nxt[`ECI_BIT_TRANSMIT_BUS_ERROR_FLAG] | irq_q[`ECI_BIT_TRANSMIT_BUS_ERROR_FLAG];
        nxt[`ECI_BIT_RECEIVE_BUS_ERROR_FLAG] = nxt[`ECI_BIT_RECEIVE_BUS_ERROR_FLAG] | irq_q[`ECI_BIT_RECEIVE_BUS_ERROR_FLAG];
      end
      // Watermark flags follow hardware only
      nxt[`ECI_BIT_EWM] = irq_q[`ECI_BIT_EWM];
      nxt[`ECI_BIT_FWM] = irq_q[`ECI_BIT_FWM];
      if (buf_inc) begin
        nxt[`ECI_BIT_EWM] = 1'b0;
      end
      if (bufdec) begin
        nxt[`ECI_BIT_FWM] = 1'b0;
      end
      if (descriptor_buffer_count_q <= wmark_q[7:0] && !buf_inc) begin
        nxt[`ECI_BIT_EWM] = 1'b1;
      end
      if (descriptor_buffer_count_q >= wmark_q[23:16] && !bufdec) begin
        nxt[`ECI_BIT_FWM] = 1'b1;
      end
      if (tx_bus_error) begin
        nxt[`ECI_BIT_TRANSMIT_BUS_ERROR_FLAG] = 1'b1;
      end
      if (rx_bus_error) begin
        nxt[`ECI_BIT_RECEIVE_BUS_ERROR_FLAG] = 1'b1;
      end
      irq_q <= nxt & `ECI_IRQ_MASK;
    end
  end
  assign irq = |irq_q;

  // Transmit sequencer: finishes the current packet after transmit request clears, drops it when module-on clears
  assign txf_valid = tx_desc_valid && run && (tx_q != eci_pkg::ECI_TX_IDLE);
  assign tx_desc_ready = txf_ready && run && (tx_q != eci_pkg::ECI_TX_IDLE);
  assign tx_done_pulse = (tx_q == eci_pkg::ECI_TX_LAST);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_q <= eci_pkg::ECI_TX_IDLE;
      last_q <= 1'b0;
    end else begin
      unique case (tx_q)
        eci_pkg::ECI_TX_IDLE: begin
          last_q <= 1'b0;
          if (ctrl_q[`ECI_BIT_TXREQ] && run) begin
            tx_q <= eci_pkg::ECI_TX_SEND;
          end
        end
        eci_pkg::ECI_TX_SEND: begin
          // Keep sending while the source offers further packets and transmit request stays set
          if (txf_valid && txf_ready) begin
            last_q <= tx_desc_last;
            if (tx_desc_last && !ctrl_q[`ECI_BIT_TXREQ]) begin
              tx_q <= eci_pkg::ECI_TX_IDLE;
            end
          end else if (!tx_desc_valid && last_q) begin
            tx_q <= eci_pkg::ECI_TX_LAST;
          end else if (!ctrl_q[`ECI_BIT_ON]) begin
            tx_q <= eci_pkg::ECI_TX_IDLE;
          end
        end
        eci_pkg::ECI_TX_LAST: begin
          last_q <= 1'b0;
          tx_q <= eci_pkg::ECI_TX_IDLE;
        end
      endcase
    end
  end

  // Outgoing packet words are buffered
  eci_fifo #(.WIDTH(32), .DEPTH(`ECI_FIFO_DEPTH), .AW(`ECI_FIFO_AW)) u_tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(txf_valid),
    .in_ready(txf_ready),
    .in_data(tx_desc_data),
    .out_valid(tx_out_valid),
    .out_ready(tx_out_ready),
    .out_data(tx_out_data),
    .level()
  );

  // Read channel
  always_comb begin
    unique case (s_axi_araddr)
      `ECI_OFF_CTRL: rdata_d = ctrl_q;
      `ECI_OFF_IRQ: rdata_d = irq_q;
      `ECI_OFF_WMARK: rdata_d = wmark_q;
      `ECI_OFF_STAT: rdata_d = {8'h00, descriptor_buffer_count_q, 15'h0000, (tx_q != eci_pkg::ECI_TX_IDLE)};
      default: rdata_d = 32'h0000_0000;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_d;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_rresp = 2'h0;
endmodule : eci_ctrl

// ### verif/eci_ctrl_asserts.sv
`timescale 1ns/10ps
module eci_ctrl_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Receive side and flags
  input wire logic rx_pkt_valid,
  input wire logic rx_pkt_store,
  input wire logic tx_bus_error,
  input wire logic rx_bus_error,
  input wire logic module_on,
  input wire logic receive_enable,
  input wire logic [7:0] descriptor_buffer_count,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_store; rx_pkt_store |-> rx_pkt_valid && module_on && receive_enable; endproperty
  a_store: assert property (p_store) else $error("packet stored while receive is off");
  property p_txerr; tx_bus_error |=> irq; endproperty
  a_txerr: assert property (p_txerr) else $error("transmit bus error left irq low");
  property p_rxerr; rx_bus_error |=> irq; endproperty
  a_rxerr: assert property (p_rxerr) else $error("receive bus error left irq low");
  property p_step; $changed(descriptor_buffer_count) |-> descriptor_buffer_count == $past(descriptor_buffer_count) + 8'h01
    || descriptor_buffer_count == $past(descriptor_buffer_count) - 8'h01; endproperty
  a_step: assert property (p_step) else $error("buffer count jumped by more than one");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped or changed early");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rdone: assert property (p_rdone) else $error("read answer repeated");
endmodule : eci_ctrl_asserts

// ### verif/eci_far_model.sv
`timescale 1ns/10ps
module eci_far_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Scenario controls
  input wire logic supply,
  input wire logic stall,
  // Packet source, three words a packet
  output logic tx_desc_valid,
  output logic [31:0] tx_desc_data,
  output logic tx_desc_last,
  input wire logic tx_desc_ready,
  // Packet sink
  input wire logic tx_out_valid,
  input wire logic [31:0] tx_out_data,
  output logic tx_out_ready,
  output int got_words,
  output logic bad
);
  logic [31:0] seq_q;
  logic [31:0] n;
  logic more;
  // Number of the next word and whether one is offered
  assign n = seq_q + {31'h0, tx_desc_valid & tx_desc_ready};
  assign more = supply || (n % 3 != 0);
  // Source holds a word until taken, finishes any packet begun, shows junk when idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_q <= 32'h0;
      tx_desc_valid <= 1'b0;
      tx_desc_data <= 32'h0;
      tx_desc_last <= 1'b0;
    end else if (!tx_desc_valid || tx_desc_ready) begin
      seq_q <= n;
      tx_desc_valid <= more;
      tx_desc_data <= more ? n : ~tx_desc_data;
      tx_desc_last <= (n % 3 == 2);
    end
  end
  // Sink takes words on alternate cycles unless stalled and checks their order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_out_ready <= 1'b0;
      got_words <= 0;
      bad <= 1'b0;
    end else begin
      tx_out_ready <= !stall && !tx_out_ready;
      if (tx_out_valid && tx_out_ready) begin
        got_words <= got_words + 1;
        if (tx_out_data !== got_words) bad <= 1'b1;
      end
    end
  end
endmodule : eci_far_model

// ### verif/test_eci_ctrl.sv
`timescale 1ns/10ps
module test_eci_ctrl;
  // Stimulus, observed outputs and bench state
  logic aclk = 1'b0, aresetn = 1'b0, supply = 1'b0, stall = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rd_v, ctl;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic idle_mode = 1'b0, rx_pkt_valid = 1'b0, rx_desc_inc = 1'b0, tx_bus_error = 1'b0, rx_bus_error = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_desc_valid, tx_desc_last;
  logic tx_desc_ready, tx_out_valid, tx_out_ready, rx_pkt_store, module_on, receive_enable, irq, bad;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, tx_desc_data, tx_out_data;
  logic [15:0] pause_timer_value;
  logic [7:0] descriptor_buffer_count;
  int got_words, failures = 0, check_count = 0, seed = 16;

  always #10 aclk = ~aclk;

  eci_ctrl eci_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .idle_mode, .tx_desc_valid,
    .tx_desc_data, .tx_desc_last, .tx_desc_ready, .tx_out_valid, .tx_out_data, .tx_out_ready, .rx_pkt_valid,
    .rx_pkt_store, .rx_desc_inc, .tx_bus_error, .rx_bus_error, .module_on, .receive_enable, .pause_timer_value,
    .descriptor_buffer_count, .irq);
  eci_far_model eci_far_model_i (.aclk, .aresetn, .supply, .stall, .tx_desc_valid, .tx_desc_data, .tx_desc_last,
    .tx_desc_ready, .tx_out_valid, .tx_out_data, .tx_out_ready, .got_words, .bad);

  // Compare one value and report a mismatch
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // One write with address and data offered together
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awready & s_axi_awvalid;
      tw = s_axi_wready & s_axi_wvalid;
      tb = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, 32'h0);
  endtask : wr

  // One read, checked against the expected word
  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arready & s_axi_arvalid;
      tr = s_axi_rvalid;
      rd_v = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tr);
    s_axi_rready <= 1'b0;
    chk(rd_v, exp);
    chk({30'h0, s_axi_rresp}, 32'h0);
  endtask : rd

  // Whether a waiting packet gets stored
  function logic exp_store(input logic [31:0] c, input logic idle);
    return c[15] & c[8] & !(c[13] & idle);
  endfunction : exp_store

  task print_verdict;
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // Watchdog
  initial begin
    #200000;
    failures++;
    print_verdict;
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h10, 32'h0000_0300);
    wr(8'h30, 32'hffff_ffff);
    rd(8'h30, 32'h0);
    wr(8'h18, 32'hffff_ffff);
    rd(8'h10, 32'h0000_6300);
    wr(8'h14, 32'h0000_6300);
    for (int i = 0; i < 2; i++) begin
      tx_bus_error <= (i == 0);
      rx_bus_error <= (i == 1);
      @(posedge aclk);
      tx_bus_error <= 1'b0;
      rx_bus_error <= 1'b0;
      rd(8'h10, (i == 0) ? 32'h0000_4300 : 32'h0000_2300);
      chk(irq, 32'h1);
      wr(8'h10, 32'h0000_0000);
      rd(8'h10, (i == 0) ? 32'h0000_4300 : 32'h0000_2300);
      wr(8'h14, 32'h0000_6300);
      rd(8'h10, 32'h0000_0300);
    end
    wr(8'h00, 32'h5a3c_8090);
    rd(8'h00, 32'h5a3c_8090);
    chk({16'h0, pause_timer_value}, 32'h0000_5a3c);
    rx_pkt_valid <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      ctl = (i < 2) ? 32'h0000_a100 : ($random(seed) & 32'h0000_a100);
      wr(8'h04, 32'h0000_a100);
      wr(8'h08, ctl);
      idle_mode <= (i < 2) ? i[0] : $random(seed);
      @(negedge aclk);
      chk(rx_pkt_store, exp_store(ctl, idle_mode));
      chk({module_on, receive_enable}, {ctl[15], ctl[8]});
    end
    wr(8'h04, 32'h0000_2000);
    wr(8'h08, 32'h0000_8100);
    idle_mode <= 1'b0;
    wr(8'h20, 32'h0003_0001);
    for (int i = 0; i < 3; i++) begin
      rx_desc_inc <= 1'b1;
      @(posedge aclk);
      rx_desc_inc <= 1'b0;
      @(posedge aclk);
    end
    rd(8'h24, 32'h0003_0000);
    chk({24'h0, descriptor_buffer_count}, 32'h3);
    rd(8'h10, 32'h0000_0100);
    wr(8'h08, 32'h0000_0001);
    rd(8'h24, 32'h0002_0000);
    rd(8'h10, 32'h0);
    wr(8'h18, 32'h0000_0300);
    rd(8'h10, 32'h0);
    chk(irq, 32'h0);
    rd(8'h00, 32'h5a3c_8190);
    supply <= 1'b1;
    stall <= 1'b1;
    wr(8'h08, 32'h0000_0200);
    repeat (40) @(posedge aclk);
    @(negedge aclk);
    chk({tx_desc_ready, tx_out_valid}, 32'h1);
    stall <= 1'b0;
    supply <= 1'b0;
    for (int n = 0; n < 400 && (tx_out_valid || tx_desc_valid); n++) @(posedge aclk);
    rd(8'h00, 32'h5a3c_8190);
    chk(got_words % 3 == 0 && got_words > 0 && !bad, 32'h1);
    supply <= 1'b1;
    wr(8'h08, 32'h0000_0200);
    repeat (7) @(posedge aclk);
    wr(8'h04, 32'h0000_0200);
    repeat (60) @(posedge aclk);
    chk(got_words % 3 == 0 && !bad, 32'h1);
    rd(8'h00, 32'h5a3c_8190);
    print_verdict;
  end
endmodule : test_eci_ctrl

bind eci_ctrl eci_ctrl_asserts eci_ctrl_asserts_i (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .rx_pkt_valid, .rx_pkt_store, .tx_bus_error,
  .rx_bus_error, .module_on, .receive_enable, .descriptor_buffer_count, .irq);
